// *** hw/frame_seq_pkg.sv ***
// Constants, field positions and state codes for the physical-layer frame sequencer.
package frame_seq_pkg;
    // Discovery-mode narrow-band preamble length in symbols.
    localparam int NB_SYMBOLS      = 163839;
    // Default preamble section lengths, in symbols; sync per device type, channel estimation shared.
    localparam int SYNC_LEN_TYPE_A = 64;
    localparam int SYNC_LEN_TYPE_B = 32;
    localparam int CE_LEN_DEFAULT  = 16;
    // Header geometry.
    localparam int FIXED_HDR_BITS  = 24;
    localparam int MAC_HDR_OCTETS  = 10;
    localparam int HCS_BITS        = 16;
    localparam int PARITY_BITS     = 128;
    localparam int CNT_W           = 18;
    // Check value generator.
    localparam logic [15:0] HCS_POLY   = 16'h1021;
    localparam logic [15:0] HCS_PRESET = 16'hFFFF;
    // Fixed header field positions; every other bit is zero.
    localparam int FH_SEED_LO = 1;
    localparam int FH_INVERT  = 3;
    localparam int FH_ATIF    = 5;
    localparam int FH_CP_LO   = 7;
    localparam int FH_CPN_LO  = 10;
    localparam int FH_NSEG_LO = 13;
    localparam int FH_NMSDU_LO = 19;
    // Sequencer states, Gray-coded along the frame order.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_NBAND = 4'h1,
        ST_SYNC  = 4'h3,
        ST_CHEST = 4'h2,
        ST_HDR   = 4'h6,
        ST_HCS   = 4'h7,
        ST_PAR   = 4'h5,
        ST_PAY   = 4'h4,
        ST_ATS   = 4'hC
    } seq_state_e;
endpackage

// *** hw/phy_frame_sequencer.sv ***
// Transmit frame sequencer: preamble, header, segmented payload, antenna training, power modes.
//
// Overview of operation
// - Components leave strictly as preamble, header, payload if any, then training if any.
// - The preamble is a narrow-band section in discovery mode, then a synchronisation sequence, then a channel estimation sequence.
// - The header stage sends the physical header, MAC header, check value and parity slots.
// - A payload holds one or more consecutive segments, and header-only frames are allowed.
// - The antenna training sequence, when requested, is always the last component.
// - All device types share one structure and differ only in parameters such as preamble.
// - In discovery mode the narrow-band preamble section lasts exactly 163839 symbols.
// - For a purely real sample stream only the real converter path is enabled.
// - In active mode a beacon window is opened in every superframe except the one at which a hibernation begins.
// - In hibernation no transmission happens until the hibernation span of superframes ends.
// - The check value is a CRC-16 (x16+x12+x5+1), preset to ones, complemented, pre-scramble.
// - Payload octets are sent least-significant bit first.
// - The 24-bit fixed physical header drives all unassigned bits to zero.
`timescale 1ns/1ps
module phy_frame_sequencer #(
    parameter int NB_LEN   = frame_seq_pkg::NB_SYMBOLS,
    parameter int SYNC_A   = frame_seq_pkg::SYNC_LEN_TYPE_A,
    parameter int SYNC_B   = frame_seq_pkg::SYNC_LEN_TYPE_B,
    parameter int CE_LEN   = frame_seq_pkg::CE_LEN_DEFAULT,
    parameter int MAC_OCT  = frame_seq_pkg::MAC_HDR_OCTETS
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 frame_req,
    input  wire logic                 dev_type_b,
    input  wire logic                 discovery,
    input  wire logic                 real_stream,
    input  wire logic [1:0]           scr_seed,
    input  wire logic                 invert_bits,
    input  wire logic [1:0]           cp_len,
    input  wire logic [1:0]           cp_len_next,
    input  wire logic [4:0]           seg_count,
    input  wire logic [4:0]           msdu_count,
    input  wire logic [15:0]          seg_octets,
    input  wire logic                 ats_req,
    input  wire logic [15:0]          ats_len,
    input  wire logic [8*MAC_OCT-1:0] mac_hdr,
    input  wire logic                 pay_valid,
    input  wire logic [7:0]           pay_data,
    output logic                      pay_ready,
    input  wire logic                 sf_tick,
    input  wire logic                 hib_req,
    input  wire logic [7:0]           hib_span,
    output logic                      sym_valid,
    output logic                      sym_bit,
    output logic [3:0]                sym_comp,
    output logic                      busy,
    output logic                      dac_re_en,
    output logic                      dac_im_en,
    output logic                      beacon_win,
    output logic                      hibernating
);
    import frame_seq_pkg::*;

    localparam int HDR_W = FIXED_HDR_BITS + 8 * MAC_OCT;

    // Refuses lengths that the symbol counter or the header register cannot hold.
    if (NB_LEN < 1 || NB_LEN >= (1 << CNT_W) || SYNC_A < 1 || SYNC_A >= (1 << CNT_W)
        || SYNC_B < 1 || SYNC_B >= (1 << CNT_W) || CE_LEN < 1 || CE_LEN >= (1 << CNT_W)
        || MAC_OCT < 1 || HDR_W >= (1 << CNT_W)) begin : g_bad_params
        $error("phy_frame_sequencer: unsupported parameter values");
    end

    // Builds the fixed physical header with reserved bits at zero.
    function automatic logic [FIXED_HDR_BITS-1:0] fixed_hdr(
        input logic [1:0] seed, input logic inv, input logic atif, input logic [1:0] cp,
        input logic [1:0] cpn, input logic [4:0] nseg, input logic [4:0] nmsdu);
        logic [FIXED_HDR_BITS-1:0] h;
        h = '0;
        h[FH_SEED_LO +: 2]  = seed;
        h[FH_INVERT]        = inv;
        h[FH_ATIF]          = atif;
        h[FH_CP_LO +: 2]    = cp;
        h[FH_CPN_LO +: 2]   = cpn;
        h[FH_NSEG_LO +: 5]  = nseg;
        h[FH_NMSDU_LO +: 5] = nmsdu;
        return h;
    endfunction

    // Advances the check value register by one transmitted bit.
    function automatic logic [15:0] hcs_step(input logic [15:0] c, input logic b);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? HCS_POLY : 16'h0000);
    endfunction

    seq_state_e        state_r, state_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [HDR_W-1:0]  hdr_r, hdr_nxt;
    logic [15:0]       crc_r, crc_nxt;
    logic [15:0]       seglen_r, seglen_nxt, atslen_r, atslen_nxt;
    logic [4:0]        segs_r, segs_nxt;
    logic              ats_r, ats_nxt, typeb_r, typeb_nxt, real_r, real_nxt;
    logic [7:0]        byte_r, byte_nxt;
    logic [2:0]        bitn_r, bitn_nxt;
    logic              have_r, have_nxt, pay_ready_nxt;
    logic [15:0]       octs_r, octs_nxt;
    logic [15:0]       lfsr_r, lfsr_nxt;
    logic              sym_valid_nxt, sym_bit_nxt, busy_nxt;
    logic [7:0]        hib_cnt_r, hib_cnt_nxt;
    logic              hib_r, hib_nxt, beacon_nxt;
    logic [CNT_W-1:0]  sync_last;

    // Next frame and power state; one symbol per cycle except payload bubbles.
    always_comb begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        hdr_nxt       = hdr_r;
        crc_nxt       = crc_r;
        seglen_nxt    = seglen_r;
        atslen_nxt    = atslen_r;
        segs_nxt      = segs_r;
        ats_nxt       = ats_r;
        typeb_nxt     = typeb_r;
        real_nxt      = real_r;
        byte_nxt      = byte_r;
        bitn_nxt      = bitn_r;
        have_nxt      = have_r;
        octs_nxt      = octs_r;
        lfsr_nxt      = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        sym_valid_nxt = 1'b1;
        sym_bit_nxt   = 1'b0;
        hib_cnt_nxt   = hib_cnt_r;
        hib_nxt       = hib_r;
        beacon_nxt    = 1'b0;
        sync_last     = typeb_r ? CNT_W'(SYNC_B - 1) : CNT_W'(SYNC_A - 1);
        unique case (state_r)
            ST_IDLE: begin
                sym_valid_nxt = 1'b0;
                // Requests are taken only in idle and never while hibernating.
                if (frame_req && !hib_r) begin
                    hdr_nxt    = {mac_hdr, fixed_hdr(scr_seed, invert_bits, ats_req, cp_len,
                                   cp_len_next, seg_count, msdu_count)};
                    segs_nxt   = seg_count;
                    seglen_nxt = seg_octets;
                    ats_nxt    = ats_req && (ats_len != 16'h0000);
                    atslen_nxt = ats_len;
                    typeb_nxt  = dev_type_b;
                    real_nxt   = real_stream;
                    crc_nxt    = HCS_PRESET;
                    cnt_nxt    = '0;
                    state_nxt  = discovery ? ST_NBAND : ST_SYNC;
                end
            end
            ST_NBAND: begin
                sym_bit_nxt = lfsr_r[0];
                cnt_nxt     = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(NB_LEN - 1)) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_SYNC;
                end
            end
            ST_SYNC: begin
                sym_bit_nxt = typeb_r ? ~lfsr_r[0] : lfsr_r[0];
                cnt_nxt     = cnt_r + 1'b1;
                if (cnt_r == sync_last) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_CHEST;
                end
            end
            ST_CHEST: begin
                sym_bit_nxt = cnt_r[0];
                cnt_nxt     = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(CE_LEN - 1)) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_HDR;
                end
            end
            ST_HDR: begin
                // Fixed header then MAC header, each LSB first, folded into the check value.
                sym_bit_nxt = hdr_r[0];
                crc_nxt     = hcs_step(crc_r, hdr_r[0]);
                hdr_nxt     = {1'b0, hdr_r[HDR_W-1:1]};
                cnt_nxt     = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(HDR_W - 1)) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_HCS;
                end
            end
            ST_HCS: begin
                sym_bit_nxt = ~crc_r[15];
                crc_nxt     = {crc_r[14:0], 1'b1};
                cnt_nxt     = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(HCS_BITS - 1)) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_PAR;
                end
            end
            ST_PAR: begin
                // Parity slots are zero here; the block encoder downstream fills them.
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(PARITY_BITS - 1)) begin
                    cnt_nxt   = '0;
                    octs_nxt  = '0;
                    state_nxt = (segs_r != 5'd0 && seglen_r != 16'h0000) ? ST_PAY
                              : (ats_r ? ST_ATS : ST_IDLE);
                end
            end
            ST_PAY: begin
                sym_valid_nxt = have_r;
                if (pay_ready && pay_valid) begin
                    byte_nxt = pay_data;
                    have_nxt = 1'b1;
                    bitn_nxt = 3'd0;
                end else if (have_r) begin
                    sym_bit_nxt = byte_r[0];
                    byte_nxt    = {1'b0, byte_r[7:1]};
                    bitn_nxt    = bitn_r + 3'd1;
                    if (bitn_r == 3'd7) begin
                        have_nxt = 1'b0;
                        octs_nxt = octs_r + 16'd1;
                        if (octs_r == seglen_r - 16'd1) begin
                            octs_nxt = '0;
                            segs_nxt = segs_r - 5'd1;
                            if (segs_r == 5'd1) begin
                                state_nxt = ats_r ? ST_ATS : ST_IDLE;
                            end
                        end
                    end
                end
            end
            ST_ATS: begin
                sym_bit_nxt = lfsr_r[1];
                cnt_nxt     = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(atslen_r) - 1'b1) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                sym_valid_nxt = 1'b0;
                state_nxt     = ST_IDLE;
            end
        endcase
        // Busy is launched from the same state as each symbol, so it covers exactly the frame.
        busy_nxt      = (state_r != ST_IDLE);
        pay_ready_nxt = (state_nxt == ST_PAY) && !have_nxt && !(pay_ready && pay_valid);
        // Power modes advance on each superframe start.
        if (sf_tick) begin
            if (hib_r) begin
                hib_cnt_nxt = hib_cnt_r - 8'd1;
                if (hib_cnt_r == 8'd1) begin
                    hib_nxt = 1'b0;
                end
            end else if (hib_req && hib_span != 8'h00 && state_r == ST_IDLE && !frame_req) begin
                hib_nxt     = 1'b1;
                hib_cnt_nxt = hib_span;
            end else begin
                beacon_nxt = 1'b1;
            end
        end
    end

    // Registers the sequencer and power state.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r     <= ST_IDLE;
            cnt_r       <= '0;
            hdr_r       <= '0;
            crc_r       <= HCS_PRESET;
            seglen_r    <= '0;
            atslen_r    <= '0;
            segs_r      <= '0;
            ats_r       <= 1'b0;
            typeb_r     <= 1'b0;
            real_r      <= 1'b0;
            byte_r      <= '0;
            bitn_r      <= '0;
            have_r      <= 1'b0;
            octs_r      <= '0;
            lfsr_r      <= 16'hACE1;
            pay_ready   <= 1'b0;
            sym_valid   <= 1'b0;
            sym_bit     <= 1'b0;
            sym_comp    <= ST_IDLE;
            busy        <= 1'b0;
            dac_re_en   <= 1'b0;
            dac_im_en   <= 1'b0;
            hib_cnt_r   <= '0;
            hib_r       <= 1'b0;
            hibernating <= 1'b0;
            beacon_win  <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            hdr_r       <= hdr_nxt;
            crc_r       <= crc_nxt;
            seglen_r    <= seglen_nxt;
            atslen_r    <= atslen_nxt;
            segs_r      <= segs_nxt;
            ats_r       <= ats_nxt;
            typeb_r     <= typeb_nxt;
            real_r      <= real_nxt;
            byte_r      <= byte_nxt;
            bitn_r      <= bitn_nxt;
            have_r      <= have_nxt;
            octs_r      <= octs_nxt;
            lfsr_r      <= lfsr_nxt;
            pay_ready   <= pay_ready_nxt;
            sym_valid   <= sym_valid_nxt && (state_r != ST_IDLE);
            sym_bit     <= sym_bit_nxt;
            sym_comp    <= state_r;
            busy        <= busy_nxt;
            dac_re_en   <= busy_nxt;
            dac_im_en   <= busy_nxt && !real_r;
            hib_cnt_r   <= hib_cnt_nxt;
            hib_r       <= hib_nxt;
            hibernating <= hib_nxt;
            beacon_win  <= beacon_nxt;
        end
    end

    // Checks on the sequencing and power behaviour.
    a_order_after_par: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_PAR && state_nxt != ST_PAR) |-> state_nxt != ST_HDR)
        else $error("component order broken after parity");
    a_sync_to_chest: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_SYNC && state_nxt == ST_CHEST) |-> cnt_r == sync_last)
        else $error("sync section length wrong");
    a_hdr_follows_ce: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_CHEST && state_nxt != ST_CHEST) |-> state_nxt == ST_HDR)
        else $error("header does not follow preamble");
    a_ats_is_last: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_ATS && state_nxt != ST_ATS) |-> state_nxt == ST_IDLE)
        else $error("component after training sequence");
    a_nband_length: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_NBAND && state_nxt == ST_SYNC) |-> cnt_r == CNT_W'(NB_LEN - 1))
        else $error("narrow-band section length wrong");
    a_imag_off_real: assert property (@(posedge mclk) disable iff (!nrst)
        (busy && real_r) |-> !dac_im_en)
        else $error("imaginary path enabled for real stream");
    a_no_tx_hibernate: assert property (@(posedge mclk) disable iff (!nrst)
        (hibernating && state_r == ST_IDLE) |=> state_r == ST_IDLE)
        else $error("frame started while hibernating");
    a_beacon_active: assert property (@(posedge mclk) disable iff (!nrst)
        (sf_tick && !hibernating && !(hib_req && hib_span != 8'h00 && state_r == ST_IDLE
         && !frame_req)) |=> beacon_win)
        else $error("beacon window missed in active mode");
    a_payload_lsb: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_PAY && have_r && !(pay_ready && pay_valid)) |=> sym_bit == $past(byte_r[0]))
        else $error("payload bit order wrong");
    a_busy_span: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(busy) |-> $past(state_r) != ST_IDLE && $past(state_r, 2) == ST_IDLE
        && $past(frame_req, 2) && !$past(hibernating, 2))
        else $error("busy rose without a taken request");
    a_busy_symbols: assert property (@(posedge mclk) disable iff (!nrst)
        sym_valid |-> busy)
        else $error("symbol emitted while not busy");
endmodule // phy_frame_sequencer

// *** sim/mac_feeder.sv ***
// Behavioural MAC payload source for the octet handshake of the frame sequencer.
`timescale 1ns/1ps
module mac_feeder (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       pay_ready,
    input  wire logic [3:0] stall,
    output logic            pay_valid,
    output logic [7:0]      pay_data
);
    logic [7:0] count;
    logic [3:0] wait_cnt;
    logic       taken;

    // Records whether the offered octet was accepted at this rising edge.
    always @(posedge mclk) begin
        taken <= pay_valid & pay_ready;
    end

    // Holds each octet until taken, then stalls; released data starts as the inverse of the last and toggles each stall cycle.
    always @(negedge mclk or negedge nrst) begin
        if (!nrst) begin
            count = 8'h00;
            wait_cnt = 4'h0;
            pay_valid = 1'b0;
            pay_data = 8'hFF;
        end else if (taken && pay_valid) begin
            pay_valid = 1'b0;
            pay_data = ~pay_data;
            count = count + 8'h01;
            wait_cnt = stall;
        end else if (!pay_valid) begin
            if (wait_cnt != 4'h0) begin
                wait_cnt = wait_cnt - 4'h1;
                pay_data = ~pay_data;
            end else begin
                pay_valid = 1'b1;
                pay_data = 8'h5A ^ count;
            end
        end
    end
endmodule // mac_feeder

// *** sim/phy_frame_sequencer_test.sv ***
// Self-checking testbench for the transmit frame sequencer.
`timescale 1ns/1ps
module phy_frame_sequencer_test;
    import frame_seq_pkg::*;
    localparam int NBL = 20;
    logic mclk, nrst, frame_req, dev_type_b, discovery, real_stream, invert_bits;
    logic [1:0] scr_seed, cp_len, cp_len_next;
    logic [4:0] seg_count, msdu_count;
    logic [15:0] seg_octets, ats_len;
    logic [79:0] mac_hdr;
    logic ats_req, pay_valid, pay_ready, sf_tick, hib_req, sym_valid, sym_bit, busy;
    logic dac_re_en, dac_im_en, beacon_win, hibernating;
    logic [7:0] pay_data, hib_span;
    logic [3:0] sym_comp, stall;
    logic [4:0] seen[$];
    logic [5:0] exp_q[$];
    int fails, compares, cycles, pay_idx;

    phy_frame_sequencer #(.NB_LEN(NBL)) i_dut (.mclk(mclk), .nrst(nrst), .frame_req(frame_req),
        .dev_type_b(dev_type_b), .discovery(discovery), .real_stream(real_stream),
        .scr_seed(scr_seed), .invert_bits(invert_bits), .cp_len(cp_len), .cp_len_next(cp_len_next),
        .seg_count(seg_count), .msdu_count(msdu_count), .seg_octets(seg_octets),
        .ats_req(ats_req), .ats_len(ats_len), .mac_hdr(mac_hdr), .pay_valid(pay_valid),
        .pay_data(pay_data), .pay_ready(pay_ready), .sf_tick(sf_tick), .hib_req(hib_req),
        .hib_span(hib_span), .sym_valid(sym_valid), .sym_bit(sym_bit), .sym_comp(sym_comp),
        .busy(busy), .dac_re_en(dac_re_en), .dac_im_en(dac_im_en), .beacon_win(beacon_win),
        .hibernating(hibernating));
    mac_feeder i_mac (.mclk(mclk), .nrst(nrst), .pay_ready(pay_ready), .stall(stall),
        .pay_valid(pay_valid), .pay_data(pay_data));

    // Clock generation at 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Captures every emitted symbol where it is settled and cuts a hung run short.
    always @(negedge mclk) begin
        cycles = cycles + 1;
        if (sym_valid === 1'b1) begin
            seen.push_back({sym_comp, sym_bit});
            if (busy !== 1'b1) check("busy during symbol", 16'h1, {15'h0, busy});
        end
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic put(input logic [3:0] comp, input logic b, input logic care, input int n);
        for (int i = 0; i < n; i++) exp_q.push_back({care, comp, b});
    endtask

    // Requests one frame, waits for it to finish and compares every symbol's component, and its bit outside preamble and training.
    task automatic run_frame(input logic typ, input logic disc, input logic rl,
                             input logic [4:0] nseg, input logic [15:0] octs,
                             input logic [15:0] alen);
        logic [23:0] fh;
        logic [103:0] hb;
        logic [15:0] crc;
        logic [7:0] d;
        int n;
        @(negedge mclk);
        dev_type_b = typ;
        discovery = disc;
        real_stream = rl;
        seg_count = nseg;
        seg_octets = octs;
        ats_req = (alen != 16'h0);
        ats_len = alen;
        seen.delete();
        exp_q.delete();
        frame_req = 1'b1;
        @(negedge mclk);
        frame_req = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        check("busy rise", 16'h1, {15'h0, busy});
        check("real dac", 16'h1, {15'h0, dac_re_en});
        check("imag dac", {15'h0, !rl}, {15'h0, dac_im_en});
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        fh = 24'h0;
        fh[2:1] = scr_seed;
        fh[3] = invert_bits;
        fh[5] = ats_req;
        fh[8:7] = cp_len;
        fh[11:10] = cp_len_next;
        fh[17:13] = nseg;
        fh[23:19] = msdu_count;
        hb = {mac_hdr, fh};
        crc = 16'hFFFF;
        for (int i = 0; i < 104; i++) crc = {crc[14:0], 1'b0} ^ ((hb[i] ^ crc[15]) ? 16'h1021 : 16'h0);
        if (disc) put(ST_NBAND, 1'b0, 1'b0, NBL);
        put(ST_SYNC, 1'b0, 1'b0, typ ? SYNC_LEN_TYPE_B : SYNC_LEN_TYPE_A);
        put(ST_CHEST, 1'b0, 1'b0, CE_LEN_DEFAULT);
        for (int i = 0; i < 104; i++) put(ST_HDR, hb[i], 1'b1, 1);
        for (int i = 15; i >= 0; i--) put(ST_HCS, ~crc[i], 1'b1, 1);
        put(ST_PAR, 1'b0, 1'b1, PARITY_BITS);
        if (nseg != 5'h0 && octs != 16'h0) begin
            for (int i = 0; i < nseg * octs; i++) begin
                d = 8'h5A ^ pay_idx[7:0];
                pay_idx++;
                for (int b = 0; b < 8; b++) put(ST_PAY, d[b], 1'b1, 1);
            end
        end
        put(ST_ATS, 1'b0, 1'b0, alen);
        check("symbol count", exp_q.size(), seen.size());
        n = (exp_q.size() < seen.size()) ? exp_q.size() : seen.size();
        for (int i = 0; i < n; i++) begin
            if (exp_q[i][5] ? (seen[i] !== exp_q[i][4:0]) : (seen[i][4:1] !== exp_q[i][4:1])) begin
                check("symbol stream", {11'h0, exp_q[i][4:0]}, {11'h0, seen[i]});
                break;
            end
        end
    endtask

    task automatic tick(input logic hib);
        @(negedge mclk);
        sf_tick = 1'b1;
        hib_req = hib;
        @(negedge mclk);
        sf_tick = 1'b0;
        hib_req = 1'b0;
    endtask

    task automatic test_frames();
        run_frame(1'b0, 1'b0, 1'b0, 5'h0, 16'h4, 16'h0);
        stall = 4'h3;
        run_frame(1'b1, 1'b1, 1'b1, 5'h2, 16'h2, 16'h5);
        stall = 4'h0;
        run_frame(1'b0, 1'b0, 1'b0, 5'h1, 16'h1, 16'h3);
        $display("test frames done");
    endtask

    // Beacon every superframe, then a two-superframe hibernation that refuses requests.
    task automatic test_power();
        for (int i = 0; i < 2; i++) begin
            tick(1'b0);
            check("beacon window", 16'h1, {15'h0, beacon_win});
        end
        hib_span = 8'h02;
        tick(1'b1);
        check("hibernating", 16'h1, {15'h0, hibernating});
        check("no beacon", 16'h0, {15'h0, beacon_win});
        frame_req = 1'b1;
        repeat (5) @(negedge mclk);
        frame_req = 1'b0;
        check("busy refused", 16'h0, {15'h0, busy});
        tick(1'b0);
        check("still hibernating", 16'h1, {15'h0, hibernating});
        tick(1'b0);
        repeat (2) @(negedge mclk);
        check("awake", 16'h0, {15'h0, hibernating});
        tick(1'b0);
        check("beacon resumed", 16'h1, {15'h0, beacon_win});
        $display("test power done");
    endtask

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Applies reset for three cycles and runs the scenarios.
    initial begin
        {frame_req, dev_type_b, discovery, real_stream, sf_tick, hib_req} = 6'h0;
        {ats_req, ats_len, seg_count, seg_octets, hib_span, stall} = 54'h0;
        scr_seed = 2'h2;
        invert_bits = 1'b1;
        cp_len = 2'h1;
        cp_len_next = 2'h3;
        msdu_count = 5'h13;
        mac_hdr = 80'hC3A5_1F00_7E81_24DB_9610;
        fails = 0;
        compares = 0;
        cycles = 0;
        pay_idx = 0;
        nrst = 1'b0;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        test_frames();
        test_power();
        report_and_stop();
    end
endmodule // phy_frame_sequencer_test
